/* File: hsd_pkg.sv */
`default_nettype none
package hsd_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [7:0] OFF_FILTER = 8'h0C;
  localparam logic [7:0] OFF_JACK = 8'h0D;
  localparam logic [7:0] OFF_DRIVER = 8'h0E;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int unsigned DEB_SAMPLES = 8;
  localparam int unsigned HP_L_LSB = 6;
  localparam int unsigned HP_R_LSB = 4;
  localparam int unsigned B_FX_L = 3;
  localparam int unsigned B_DEEMP_L = 2;
  localparam int unsigned B_FX_R = 1;
  localparam int unsigned B_DEEMP_R = 0;
  localparam int unsigned B_DET_EN = 7;
  localparam int unsigned TYPE_LSB = 5;
  localparam int unsigned JDEB_LSB = 2;
  localparam int unsigned BDEB_LSB = 0;
  localparam int unsigned B_ACCPL = 7;
  localparam int unsigned B_FULLDIFF = 6;
  localparam int unsigned B_BTN = 5;
  localparam int unsigned B_PRESENT = 4;
  localparam int unsigned B_PSEUDODIFF = 3;
  // Jack tick is 2 ms shifted by code, code 7 wrapping to 1 ms; button tick 1 ms shifted by code-1
  localparam logic [2:0] JACK_BASE_SHIFT = 3'h1;
  typedef struct packed {
    logic [1:0] hp_left;
    logic [1:0] hp_right;
    logic fx_left;
    logic deemp_left;
    logic fx_right;
    logic deemp_right;
  } filter_ctl_s;
  typedef struct packed {
    logic ac_coupled;
    logic full_diff;
    logic pseudo_diff;
  } driver_ctl_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage
`default_nettype wire

/* File: hsd_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module hsd_tick
  import hsd_pkg::*;
#(
  // Clocks per 1 ms tick
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  output logic ms_tick
);
  logic [$clog2(TICK_CYCLES)-1:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      ms_tick <= 1'b0;
    end else if (ce) begin
      ms_tick <= (cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
      if (cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hsd_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
// Accepts a new level after DEB_SAMPLES equal samples on sample ticks
module hsd_debounce
  import hsd_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bypass,
  input wire logic sample,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);
  logic [W-1:0] last_q;
  logic [$clog2(DEB_SAMPLES+1)-1:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= '0;
      cnt_q <= '0;
      stable <= '0;
    end else if (ce) begin
      if (bypass) begin
        stable <= raw;
        last_q <= raw;
        cnt_q <= '0;
      end else if (sample) begin
        last_q <= raw;
        if (raw != last_q) begin
          cnt_q <= '0;
        end else if (cnt_q == ($clog2(DEB_SAMPLES+1))'(DEB_SAMPLES - 1)) begin
          stable <= raw;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: hsd_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module filter_and_headset_detect_regs
  import hsd_pkg::*;
#(
  // Clocks per 1 ms debounce tick; shortened only to speed up checks
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic stereo_sense,
  input wire logic cell_sense,
  input wire logic button_sense,
  output filter_ctl_s filter_ctl,
  output driver_ctl_s driver_ctl,
  output logic detect_enable
);
  logic [7:0] filt_q;
  logic det_en_q;
  logic [2:0] jdeb_q;
  logic [1:0] bdeb_q;
  logic [1:0] type_q;
  logic btn_flag_q;
  driver_ctl_s drv_q;
  logic [2:0] sync_a_q, sync_b_q;
  logic ms_tick;
  logic [6:0] div_q;
  logic jack_sample, btn_sample;
  logic [1:0] jack_stable;
  logic btn_stable, btn_prev_q;
  logic btn_press;

  function automatic logic [6:0] tick_mask(input logic [2:0] shift);
    tick_mask = 7'((8'h01 << shift) - 8'h01);
  endfunction

  // Pins from outside pass two flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end else if (ce) begin
      sync_a_q <= {button_sense, cell_sense, stereo_sense};
      sync_b_q <= sync_a_q;
    end
  end

  hsd_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .ms_tick(ms_tick)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else if (ce && ms_tick) begin
      div_q <= div_q + 1'b1;
    end
  end

  // jack sample period 2 ms doubling per code, wrapping to 1 ms at code 7
  assign jack_sample = ms_tick && ((div_q & tick_mask(jdeb_q + JACK_BASE_SHIFT)) == '0);
  // button sample 1, 2 or 4 ms
  assign btn_sample = ms_tick && ((div_q & tick_mask(3'(bdeb_q) - 3'h1)) == '0);

  hsd_debounce #(.W(2)) u_jack_deb (
    .clk(clk),
    .rst(rst),
    .ce(ce && det_en_q),
    .bypass(1'b0),
    .sample(jack_sample),
    .raw(sync_b_q[1:0]),
    .stable(jack_stable)
  );

  hsd_debounce #(.W(1)) u_btn_deb (
    .clk(clk),
    .rst(rst),
    .ce(ce && det_en_q),
    .bypass(bdeb_q == 2'h0),
    .sample(btn_sample),
    .raw(sync_b_q[2]),
    .stable(btn_stable)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_prev_q <= 1'b0;
    end else if (ce) begin
      btn_prev_q <= btn_stable;
    end
  end
  assign btn_press = det_en_q && btn_stable && !btn_prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_q <= RST_REG;
    end else if (ce && wr && addr == OFF_FILTER) begin
      filt_q <= wdata;
    end
  end
  assign filter_ctl.hp_left = filt_q[HP_L_LSB +: 2];
  assign filter_ctl.hp_right = filt_q[HP_R_LSB +: 2];
  assign filter_ctl.fx_left = filt_q[B_FX_L];
  assign filter_ctl.deemp_left = filt_q[B_DEEMP_L];
  assign filter_ctl.fx_right = filt_q[B_FX_R];
  assign filter_ctl.deemp_right = filt_q[B_DEEMP_R];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_en_q <= 1'b0;
      jdeb_q <= '0;
      bdeb_q <= '0;
    end else if (ce && wr && addr == OFF_JACK) begin
      det_en_q <= wdata[B_DET_EN];
      jdeb_q <= wdata[JDEB_LSB +: 3];
      bdeb_q <= wdata[BDEB_LSB +: 2];
    end
  end
  assign detect_enable = det_en_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      type_q <= '0;
    end else if (ce && det_en_q) begin
      type_q <= {jack_stable[1], jack_stable[0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_q <= '0;
    end else if (ce && wr && addr == OFF_DRIVER) begin
      drv_q.ac_coupled <= wdata[B_ACCPL];
      drv_q.full_diff <= wdata[B_FULLDIFF];
      drv_q.pseudo_diff <= wdata[B_PSEUDODIFF];
    end
  end
  assign driver_ctl = drv_q;

  // sticky flag, set wins over read clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_flag_q <= 1'b0;
    end else if (ce) begin
      if (btn_press) begin
        btn_flag_q <= 1'b1;
      end else if (rd && addr == OFF_DRIVER) begin
        btn_flag_q <= 1'b0;
      end
    end
  end

  // Read data one cycle after strobe, zero otherwise while ce is high; held while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          OFF_FILTER: rdata <= filt_q;
          OFF_JACK: rdata <= {det_en_q, type_q, jdeb_q, bdeb_q};
          OFF_DRIVER: rdata <= {drv_q.ac_coupled, drv_q.full_diff, btn_flag_q,
                                (type_q != 2'h0), drv_q.pseudo_diff, 3'h0};
          default: rdata <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: hsd_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module hsd_regs_chk
  import hsd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic stereo_sense,
  input wire logic cell_sense,
  input wire logic button_sense,
  input wire filter_ctl_s filter_ctl,
  input wire driver_ctl_s driver_ctl,
  input wire logic detect_enable
);
  wire logic wf = ce && wr && addr == OFF_FILTER;
  wire logic wj = ce && wr && addr == OFF_JACK;
  wire logic wd = ce && wr && addr == OFF_DRIVER;
  wire logic rf = ce && rd && addr == OFF_FILTER;
  wire logic rj = ce && rd && addr == OFF_JACK;
  wire logic rdd = ce && rd && addr == OFF_DRIVER;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_hpf_write: assert property (wf |=> filter_ctl[7:4] == $past(wdata[7:4]))
    else $error("high-pass fields differ from write");
  a_dac_write: assert property (wf |=> filter_ctl[3:0] == $past(wdata[3:0]))
    else $error("dac filter bits differ from write");
  a_filter_hold: assert property (!wf |=> $stable(filter_ctl))
    else $error("filter control changed without write");
  a_filter_read: assert property (rf |=> rdata == $past(filter_ctl))
    else $error("filter readback wrong");
  a_det_write: assert property (wj |=> detect_enable == $past(wdata[7]))
    else $error("detect enable differs from write");
  a_det_hold: assert property (!wj |=> $stable(detect_enable))
    else $error("detect enable changed without write");
  a_det_read: assert property (rj |=> rdata[7] == $past(detect_enable))
    else $error("detect enable readback wrong");
  a_drv_write: assert property (wd |=> driver_ctl == $past({wdata[7:6], wdata[3]}))
    else $error("driver control differs from write");
  a_drv_hold: assert property (!wd |=> $stable(driver_ctl))
    else $error("driver control changed without write");
  a_rsvd_zero: assert property (rdd |=> rdata[2:0] == 3'h0)
    else $error("reserved driver bits read nonzero");
endmodule
bind filter_and_headset_detect_regs hsd_regs_chk i_chk (.clk(clk), .rst(rst), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stereo_sense(stereo_sense),
  .cell_sense(cell_sense), .button_sense(button_sense), .filter_ctl(filter_ctl),
  .driver_ctl(driver_ctl), .detect_enable(detect_enable));
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module tb;
  import hsd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, seen = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, d;
  logic [7:0] rdata;
  logic [7:0] want;
  logic st = 1'b0, cl = 1'b0, bt = 1'b0, det;
  filter_ctl_s fc;
  driver_ctl_s dc;
  logic [7:0] exp_q[$];
  int bad_count = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  filter_and_headset_detect_regs #(.TICK_CYCLES(8)) i_dut (.clk(clk), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stereo_sense(st),
    .cell_sense(cl), .button_sense(bt), .filter_ctl(fc), .driver_ctl(dc), .detect_enable(det));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; exp_q.push_back(e); end
    @(posedge clk) rd <= 1'b0;
  endtask
  // Read data checked one cycle after each read
  always @(posedge clk) begin
    if (seen) begin
      want = exp_q.pop_front();
      `CHK(rdata, want)
    end
    seen <= rd;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h460F));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFF_FILTER, 8'h00);
    rd_reg(OFF_JACK, 8'h00);
    rd_reg(OFF_DRIVER, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], ~i[1:0], 4'($urandom)};
      wr_reg(OFF_FILTER, d);
      @(negedge clk) `CHK(fc, filter_ctl_s'(d))
      rd_reg(OFF_FILTER, d);
    end
    wr_reg(8'h0F, 8'hFF);
    rd_reg(8'h0B, 8'h00);
    `CHK(fc, filter_ctl_s'(d))
    // Clock enable low freezes writes and read data
    @(posedge clk) ce <= 1'b0;
    wr_reg(OFF_FILTER, ~d);
    rd_reg(OFF_FILTER, 8'h00);
    @(posedge clk) ce <= 1'b1;
    `CHK(fc, filter_ctl_s'(d))
    $display("filter test done");
    for (int j = 0; j < 6; j++) begin
      d = {3'h4, j[2:0], j[1:0]};
      wr_reg(OFF_JACK, d | 8'h60);
      rd_reg(OFF_JACK, d);
      `CHK(det, 1'b1)
    end
    $display("jack test done");
    wr_reg(OFF_DRIVER, 8'hF0);
    rd_reg(OFF_DRIVER, 8'hC0);
    `CHK(dc, driver_ctl_s'(3'h6))
    wr_reg(OFF_DRIVER, 8'h08);
    rd_reg(OFF_DRIVER, 8'h08);
    `CHK(dc, driver_ctl_s'(3'h1))
    $display("driver test done");
    wr_reg(OFF_JACK, 8'h81);
    @(posedge clk) bt <= 1'b1;
    repeat (40) @(posedge clk);
    @(posedge clk) bt <= 1'b0;
    repeat (150) @(posedge clk);
    rd_reg(OFF_DRIVER, 8'h08);
    @(posedge clk) bt <= 1'b1;
    repeat (150) @(posedge clk);
    rd_reg(OFF_DRIVER, 8'h28);
    @(posedge clk) bt <= 1'b0;
    repeat (150) @(posedge clk);
    wr_reg(OFF_JACK, 8'h80);
    @(posedge clk) bt <= 1'b1;
    repeat (10) @(posedge clk);
    rd_reg(OFF_DRIVER, 8'h28);
    rd_reg(OFF_DRIVER, 8'h08);
    @(posedge clk) bt <= 1'b0;
    $display("button test done");
    wr_reg(OFF_JACK, 8'h00);
    @(posedge clk) begin st <= 1'b1; cl <= 1'b1; end
    repeat (400) @(posedge clk);
    rd_reg(OFF_JACK, 8'h00);
    rd_reg(OFF_DRIVER, 8'h08);
    `CHK(det, 1'b0)
    $display("disabled detect test done");
    wr_reg(OFF_JACK, 8'h80);
    repeat (400) @(posedge clk);
    rd_reg(OFF_JACK, 8'hE0);
    rd_reg(OFF_DRIVER, 8'h18);
    @(posedge clk) cl <= 1'b0;
    repeat (400) @(posedge clk);
    rd_reg(OFF_JACK, 8'hA0);
    @(posedge clk) st <= 1'b0;
    repeat (400) @(posedge clk);
    rd_reg(OFF_DRIVER, 8'h08);
    repeat (2) @(posedge clk);
    $display("detect test done");
    print_verdict();
  end
endmodule
`default_nettype wire
